// File: hw/cpfs_defs.svh
`ifndef CPFS_DEFS_SVH
`define CPFS_DEFS_SVH

// ==========================================================
// register offsets (byte addresses on the avalon slave)
`define CPFS_REG_CTRL 4'h0
`define CPFS_REG_STATUS 4'h4
`define CPFS_REG_PINS 4'h8

// ==========================================================
// ctrl fields and reset value
`define CPFS_CTRL_OUT_DIS 0
`define CPFS_CTRL_RST 1'h0

// ==========================================================
// status fields
`define CPFS_ST_MODE_LO 0
`define CPFS_ST_BUS_STYLE 2
`define CPFS_ST_OUT_DIS 3
`define CPFS_ST_TX_CLK_LO 4

// ==========================================================
// pins register fields
`define CPFS_PIN_AD_LO 0
`define CPFS_PIN_ADDR_LO 8

// ==========================================================
// widths and synchroniser layout
`define CPFS_SYNC_W 19
`define CPFS_DATA_ZERO 32'h0000_0000

`endif

// File: hw/cpfs_pkg.sv
package cpfs_pkg;

  // interface-mode strap decode
  typedef enum logic [1:0] {
    cpfs_mode_mux = 2'b00,
    cpfs_mode_nonmux = 2'b01,
    cpfs_mode_serial = 2'b10,
    cpfs_mode_hw = 2'b11
  } cpfs_mode_t;

endpackage

// File: hw/cpfs_mode_if.sv
`timescale 1ns/1ps

// ==========================================================
// strap-to-function decode carried between decoder and top
interface cpfs_mode_if;
  import cpfs_pkg::*;
  logic [1:0] strap;
  cpfs_mode_t mode;
  logic is_par;
  logic is_mux;
  logic is_nonmux;
  logic is_serial;
  logic is_hw;

  modport dec (
    input strap,
    output mode,
    output is_par,
    output is_mux,
    output is_nonmux,
    output is_serial,
    output is_hw
  );
  modport use_side (
    output strap,
    input mode,
    input is_par,
    input is_mux,
    input is_nonmux,
    input is_serial,
    input is_hw
  );
endinterface

// File: hw/cpfs_sync.sv
`timescale 1ns/1ps

// ==========================================================
// three-stage pin synchroniser; a change counts once stages two and three agree
module cpfs_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  // pins and result
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);
  logic [W-1:0] s1_ff;
  logic [W-1:0] s2_ff;
  logic [W-1:0] s3_ff;
  logic [W-1:0] out_ff;
  logic [W-1:0] nxt_out;

  // per-bit filter: hold the old value while the last two stages disagree
  always_comb begin
    for (int i = 0; i < W; i++) begin
      nxt_out[i] = (s2_ff[i] == s3_ff[i]) ? s3_ff[i] : out_ff[i];
    end
  end

  // only stage two reads stage one
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      s1_ff <= '0;
      s2_ff <= '0;
      s3_ff <= '0;
      out_ff <= '0;
    end else begin
      s1_ff <= i_async;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      out_ff <= nxt_out;
    end
  end

  assign o_sync = out_ff;
endmodule

// File: hw/cpfs_mode_dec.sv
`timescale 1ns/1ps

// ==========================================================
// interface-mode strap decode, purely combinational
module cpfs_mode_dec
  import cpfs_pkg::*;
(
  cpfs_mode_if.dec mif
);
  // strap is static in use, so no state is kept here
  always_comb begin
    mif.mode = cpfs_mode_t'(mif.strap);
    mif.is_mux = 1'b0;
    mif.is_nonmux = 1'b0;
    mif.is_serial = 1'b0;
    mif.is_hw = 1'b0;
    case (mif.mode)
      cpfs_mode_mux: mif.is_mux = 1'b1;
      cpfs_mode_nonmux: mif.is_nonmux = 1'b1;
      cpfs_mode_serial: mif.is_serial = 1'b1;
      default: mif.is_hw = 1'b1;
    endcase
    mif.is_par = mif.is_mux | mif.is_nonmux;
  end
endmodule

// File: hw/cpfs_top.sv
`timescale 1ns/1ps
`include "cpfs_defs.svh"

// Notes on behaviour
// RULE_01: strap 01: low pins are data bus
// RULE_02: strap 00: pins shared address and data
// RULE_03: serial: read data bit0, write data bit1
// RULE_04: nonmux: dedicated pins give address six..zero
// RULE_05: host ties unused address pins low, mux
// RULE_06: serial: straps set clock polarity and phase
// RULE_07: hardware: pins give rx, tx mode bits
// RULE_08: hardware: prescale input sets clock divide
// RULE_09: hardware: three pins give build-out code
// RULE_10: alarm high in T1/E1 sends AIS
// RULE_11: composite clock: alarm low forces all ones
// RULE_12: termination select: 0=120 ohm, 1=75 ohm
// RULE_13: bus-type strap picks strobe timing style
// RULE_14: hardware T1/E1: line-code input enables substitution
// RULE_15: strap 00 mux, 01 nonmux, 10 serial, 11 hw
// RULE_16: host holds chip select low per access
// RULE_17: pin function follows static strap combinationally; here the strap passes cpfs_sync and the function outputs are registered
module cpfs_top
  import cpfs_pkg::*;
(
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  // avalon-mm slave
  input wire logic [3:0] i_av_address,
  input wire logic i_av_read,
  input wire logic i_av_write,
  input wire logic [31:0] i_av_writedata,
  output logic [31:0] o_av_readdata,
  output logic o_av_waitrequest,
  // strap pins
  input wire logic [1:0] i_interface_mode_strap,
  input wire logic i_bus_style_strap,
  input wire logic i_tx_clk_src_sel_1,
  // shared address/data pins
  input wire logic [7:0] i_ad_pin,
  output logic [7:0] o_ad_pin,
  output logic [7:0] o_ad_pin_oe,
  input wire logic [6:0] i_addr_pin,
  // parallel port engine
  input wire logic [7:0] i_par_rdata,
  input wire logic i_par_rd_drive,
  output logic o_par_ad_shared,
  output logic o_par_nonmux,
  output logic [7:0] o_par_data_in,
  output logic [6:0] o_par_addr,
  output logic o_bus_style_strobe,
  // serial port engine
  input wire logic i_spi_miso,
  input wire logic i_spi_miso_drive,
  output logic o_spi_en,
  output logic o_spi_mosi,
  output logic o_spi_cpol,
  output logic o_spi_cpha,
  // hardware mode and transmitter
  input wire logic i_tx_mode_t1e1,
  input wire logic i_tx_mode_cc,
  output logic o_hw_mode,
  output logic o_rx_mode_sel_bit3,
  output logic o_tx_mode_sel_bit0,
  output logic o_prescale_sel_0,
  output logic [2:0] o_buildout_sel,
  output logic o_term_75_ohm,
  output logic o_zero_sub_code_en,
  output logic o_tx_send_ais,
  output logic o_tx_force_ones,
  output logic [1:0] o_tx_clk_src_sel
);

  // ==========================================================
  // pin synchronisers and strap decode
  logic [18:0] sync_s;
  logic [7:0] ad_s;
  logic [6:0] addr_s;
  logic bus_style_s;
  logic tx_clk1_s;
  logic alarm_tx_in;
  logic e1_term_sel;
  logic zero_sub_code_en;
  cpfs_mode_if mif ();

  cpfs_sync #(.W(`CPFS_SYNC_W)) u_sync (
    .i_clk_sys(i_clk_sys),
    .i_nrst(i_nrst),
    .i_async({i_tx_clk_src_sel_1, i_bus_style_strap, i_interface_mode_strap,
              i_addr_pin, i_ad_pin}),
    .o_sync(sync_s)
  );

  // unpack the filtered pins
  assign ad_s = sync_s[7:0];
  assign addr_s = sync_s[14:8];
  assign mif.strap = sync_s[16:15];
  assign bus_style_s = sync_s[17];
  assign tx_clk1_s = sync_s[18];
  assign alarm_tx_in = addr_s[1];
  assign e1_term_sel = addr_s[0];
  assign zero_sub_code_en = bus_style_s;

  cpfs_mode_dec u_dec (
    .mif(mif)
  ); // RULE_15 RULE_17

  // ==========================================================
  // register bus
  logic ctrl_out_dis_ff;
  logic nxt_ctrl_out_dis;
  logic wait_ff;
  logic nxt_wait;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  logic av_req;

  assign av_req = i_av_read | i_av_write;

  // read mux shared by the read path
  function automatic logic [31:0] cpfs_read_word(input logic [3:0] addr,
                                                 input logic [31:0] st,
                                                 input logic [31:0] pins,
                                                 input logic dis);
    logic [31:0] w;
    w = `CPFS_DATA_ZERO;
    if (addr == `CPFS_REG_CTRL) begin
      w[`CPFS_CTRL_OUT_DIS] = dis;
    end else if (addr == `CPFS_REG_STATUS) begin
      w = st;
    end else if (addr == `CPFS_REG_PINS) begin
      w = pins;
    end
    return w;
  endfunction

  logic [31:0] status_word;
  logic [31:0] pins_word;

  // status shows decoded mode and straps as the block sees them
  always_comb begin
    status_word = `CPFS_DATA_ZERO;
    status_word[`CPFS_ST_MODE_LO +: 2] = mif.mode;
    status_word[`CPFS_ST_BUS_STYLE] = bus_style_s;
    status_word[`CPFS_ST_OUT_DIS] = ctrl_out_dis_ff;
    status_word[`CPFS_ST_TX_CLK_LO +: 2] = {tx_clk1_s, ad_s[0]};
    pins_word = `CPFS_DATA_ZERO;
    pins_word[`CPFS_PIN_AD_LO +: 8] = ad_s;
    pins_word[`CPFS_PIN_ADDR_LO +: 7] = addr_s;
  end

  // one wait cycle per access; write lands on the edge that sees waitrequest low
  always_comb begin
    nxt_wait = ~(av_req & wait_ff);
    nxt_rdata = rdata_ff;
    nxt_ctrl_out_dis = ctrl_out_dis_ff;
    if (i_av_read && wait_ff) begin
      nxt_rdata = cpfs_read_word(i_av_address, status_word, pins_word, ctrl_out_dis_ff);
    end
    if (i_av_write && !wait_ff && i_av_address == `CPFS_REG_CTRL) begin
      nxt_ctrl_out_dis = i_av_writedata[`CPFS_CTRL_OUT_DIS];
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      wait_ff <= 1'b1;
      rdata_ff <= `CPFS_DATA_ZERO;
      ctrl_out_dis_ff <= `CPFS_CTRL_RST;
    end else begin
      wait_ff <= nxt_wait;
      rdata_ff <= nxt_rdata;
      ctrl_out_dis_ff <= nxt_ctrl_out_dis;
    end
  end

  assign o_av_waitrequest = wait_ff;
  assign o_av_readdata = rdata_ff;

  // ==========================================================
  // pin function select
  logic [7:0] ad_out_ff;
  logic [7:0] nxt_ad_out;
  logic [7:0] ad_oe_ff;
  logic [7:0] nxt_ad_oe;
  logic [27:0] fn_ff;
  logic [27:0] nxt_fn;

  // pin drivers; ctrl disable tri-states everything for board testing
  always_comb begin
    nxt_ad_out = 8'h00;
    nxt_ad_oe = 8'h00;
    if (mif.is_par && i_par_rd_drive) begin
      nxt_ad_out = i_par_rdata; // RULE_01 RULE_02
      nxt_ad_oe = 8'hff;
    end else if (mif.is_serial && i_spi_miso_drive) begin
      nxt_ad_out = {7'h00, i_spi_miso}; // RULE_03
      nxt_ad_oe = 8'h01;
    end
    if (ctrl_out_dis_ff) begin
      nxt_ad_oe = 8'h00;
    end
  end

  // function outputs; inactive functions read as zero
  always_comb begin
    nxt_fn = '0;
    // parallel side: mux mode relies on unused address pins tied low
    nxt_fn[0] = mif.is_mux; // RULE_02 RULE_05
    nxt_fn[1] = mif.is_nonmux; // RULE_01
    nxt_fn[9:2] = mif.is_par ? ad_s : 8'h00;
    nxt_fn[16:10] = mif.is_nonmux ? addr_s : 7'h00; // RULE_04
    nxt_fn[17] = mif.is_par & bus_style_s; // RULE_13
    // serial side
    nxt_fn[18] = mif.is_serial;
    nxt_fn[19] = mif.is_serial & ad_s[1]; // RULE_03
    nxt_fn[20] = mif.is_serial & addr_s[5]; // RULE_06
    nxt_fn[21] = mif.is_serial & addr_s[4]; // RULE_06
    // hardware strap side
    nxt_fn[22] = mif.is_hw;
    if (mif.is_hw) begin
      nxt_fn[23] = ad_s[1]; // RULE_07
      nxt_fn[24] = addr_s[5]; // RULE_07
      nxt_fn[25] = addr_s[6]; // RULE_08
      nxt_fn[26] = e1_term_sel; // RULE_12
      nxt_fn[27] = zero_sub_code_en & i_tx_mode_t1e1; // RULE_14
    end
  end

  // transmitter alarm and clock-source straps
  logic tx_ais_ff;
  logic nxt_tx_ais;
  logic tx_ones_ff;
  logic nxt_tx_ones;
  logic [2:0] bo_ff;
  logic [2:0] nxt_bo;
  logic [1:0] tclk_ff;
  logic [1:0] nxt_tclk;

  // alarm pin is only free in hardware mode; elsewhere it is an address bit
  always_comb begin
    nxt_tx_ais = mif.is_hw & i_tx_mode_t1e1 & alarm_tx_in; // RULE_10
    nxt_tx_ones = mif.is_hw & i_tx_mode_cc & ~alarm_tx_in; // RULE_11
    nxt_bo = mif.is_hw ? addr_s[4:2] : 3'h0; // RULE_09
    nxt_tclk = mif.is_hw ? {tx_clk1_s, ad_s[0]} : {tx_clk1_s, 1'b0};
  end

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      ad_out_ff <= 8'h00;
      ad_oe_ff <= 8'h00;
      fn_ff <= '0;
      tx_ais_ff <= 1'b0;
      tx_ones_ff <= 1'b0;
      bo_ff <= 3'h0;
      tclk_ff <= 2'h0;
    end else begin
      ad_out_ff <= nxt_ad_out;
      ad_oe_ff <= nxt_ad_oe;
      fn_ff <= nxt_fn;
      tx_ais_ff <= nxt_tx_ais;
      tx_ones_ff <= nxt_tx_ones;
      bo_ff <= nxt_bo;
      tclk_ff <= nxt_tclk;
    end
  end

  // output fan-out of the registered functions
  assign o_ad_pin = ad_out_ff;
  assign o_ad_pin_oe = ad_oe_ff;
  assign o_par_ad_shared = fn_ff[0];
  assign o_par_nonmux = fn_ff[1];
  assign o_par_data_in = fn_ff[9:2];
  assign o_par_addr = fn_ff[16:10];
  assign o_bus_style_strobe = fn_ff[17];
  assign o_spi_en = fn_ff[18];
  assign o_spi_mosi = fn_ff[19];
  assign o_spi_cpol = fn_ff[20];
  assign o_spi_cpha = fn_ff[21];
  assign o_hw_mode = fn_ff[22];
  assign o_rx_mode_sel_bit3 = fn_ff[23];
  assign o_tx_mode_sel_bit0 = fn_ff[24];
  assign o_prescale_sel_0 = fn_ff[25];
  assign o_term_75_ohm = fn_ff[26];
  assign o_zero_sub_code_en = fn_ff[27];
  assign o_tx_send_ais = tx_ais_ff;
  assign o_tx_force_ones = tx_ones_ff;
  assign o_buildout_sel = bo_ff;
  assign o_tx_clk_src_sel = tclk_ff;

  // ==========================================================
  // assertions
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_nrst);

  nonmux_data_a: assert property ( // RULE_01
    (mif.is_nonmux && i_par_rd_drive && !ctrl_out_dis_ff) |=>
      (o_ad_pin_oe == 8'hff && o_ad_pin == $past(i_par_rdata) && o_par_nonmux))
    else $error("nonmux read data not driven on shared pins");
  mux_shared_a: assert property ( // RULE_02
    mif.is_mux |=> (o_par_ad_shared && o_par_addr == 7'h00 && !o_spi_en && !o_hw_mode))
    else $error("mux mode did not share pins");
  serial_pins_a: assert property ( // RULE_03
    o_spi_en |-> (o_ad_pin_oe[7:1] == 7'h00 && o_par_data_in == 8'h00))
    else $error("serial mode drove more than the read data pin");
  nonmux_addr_a: assert property ( // RULE_04
    mif.is_nonmux ##1 mif.is_nonmux |-> o_par_addr == $past(addr_s))
    else $error("nonmux address not taken from dedicated pins");
  spi_clk_cfg_a: assert property ( // RULE_06
    (o_spi_cpol || o_spi_cpha) |-> (o_spi_en && !o_hw_mode && !o_par_nonmux))
    else $error("clock polarity or phase outside serial mode");
  hw_only_sel_a: assert property ( // RULE_07
    (o_rx_mode_sel_bit3 || o_tx_mode_sel_bit0 || o_prescale_sel_0) |-> o_hw_mode)
    else $error("hardware select seen outside hardware mode");
  prescale_sel_a: assert property ( // RULE_08
    mif.is_hw |=> o_prescale_sel_0 == $past(addr_s[6]))
    else $error("prescale select not following its pin");
  buildout_sel_a: assert property ( // RULE_09
    mif.is_hw |=> o_buildout_sel == $past(addr_s[4:2]))
    else $error("build-out code not following its pins");
  alarm_ais_a: assert property ( // RULE_10
    (mif.is_hw && i_tx_mode_t1e1 && alarm_tx_in) |=> o_tx_send_ais)
    else $error("alarm pattern not sent");
  alarm_cc_a: assert property ( // RULE_11
    o_tx_force_ones |-> (!o_tx_send_ais && o_hw_mode))
    else $error("all-ones forced with alarm or outside hardware mode");
  alarm_ones_a: assert property ( // RULE_11
    (mif.is_hw && i_tx_mode_cc && !alarm_tx_in) |=> o_tx_force_ones)
    else $error("all-ones not forced with alarm low");
  term_sel_a: assert property ( // RULE_12
    o_term_75_ohm |-> o_hw_mode)
    else $error("termination select outside hardware mode");
  bus_style_a: assert property ( // RULE_13
    (mif.is_par && bus_style_s) |=> o_bus_style_strobe)
    else $error("strobe timing style not selected");
  zero_sub_a: assert property ( // RULE_14
    o_zero_sub_code_en |-> (o_hw_mode && $past(i_tx_mode_t1e1)))
    else $error("zero substitution outside hardware line mode");
  bus_answer_a: assert property (
    (av_req && o_av_waitrequest) |=> !o_av_waitrequest ##1 o_av_waitrequest)
    else $error("bus answer not one cycle after request");

  cov_mux_c: cover property (o_par_ad_shared && o_ad_pin_oe == 8'hff);
  cov_serial_c: cover property (o_spi_en && o_ad_pin_oe == 8'h01);
  cov_hw_ais_c: cover property (o_hw_mode && o_tx_send_ais);
  cov_ctrl_wr_c: cover property (i_av_write && !o_av_waitrequest);

endmodule

// File: verification/cpfs_host_model.sv
`timescale 1ns/1ps

// ==========================================================
// board and host side of the shared and dedicated control pins
module cpfs_host_model (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  // device drive
  input wire logic [7:0] i_dut_ad,
  input wire logic [7:0] i_dut_oe,
  // host drive
  input wire logic [7:0] i_host_ad,
  input wire logic [7:0] i_host_oe,
  input wire logic [6:0] i_host_addr,
  input wire logic i_mux_sel,
  // resolved pin levels
  output logic [7:0] o_ad_wire,
  output logic [6:0] o_addr_wire
);
  logic [7:0] last_ff;

  // no pull on the shared lines, so a floating bit flips every cycle
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (i_dut_oe[i]) begin
        o_ad_wire[i] = i_dut_ad[i];
      end else if (i_host_oe[i]) begin
        o_ad_wire[i] = i_host_ad[i];
      end else begin
        o_ad_wire[i] = ~last_ff[i];
      end
    end
  end

  // last level seen on each shared line
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      last_ff <= 8'h00;
    end else begin
      last_ff <= o_ad_wire;
    end
  end

  // board ties the unused address pins low in multiplexed mode
  assign o_addr_wire = i_mux_sel ? 7'h00 : i_host_addr;
endmodule

// File: verification/cpfs_bench.sv
`timescale 1ns/1ps

// ==========================================================
// self-checking bench for the control port pin function select
module cpfs_bench;
  import cpfs_pkg::*;
  logic clk = 1'b0, nrst = 1'b0;
  logic [3:0] av_a = 4'h0;
  logic av_rd = 1'b0, av_wr = 1'b0;
  logic [31:0] av_wd = 32'h0000_0000;
  logic [31:0] av_rdata;
  logic av_wait;
  logic [1:0] strap = 2'h0;
  logic bstyle = 1'b0, tclk1 = 1'b0, rd_drv = 1'b0, miso = 1'b0, miso_drv = 1'b0;
  logic t1e1 = 1'b0, cc = 1'b0;
  logic [7:0] par_rdata = 8'h00, h_ad = 8'h00, h_oe = 8'h00, ad_out, ad_oe, ad_wire;
  logic [6:0] h_addr = 7'h00, addr_wire, par_addr;
  logic [7:0] data_in;
  logic shared, nonmux, strobe, spi_en, mosi, cpol, cpha, hw, rx3, tx0, psel, term, zsub;
  logic ais, ones;
  logic [2:0] bo;
  logic [1:0] csrc;
  logic [31:0] rd;
  int fails = 0, tests_run = 0, cyc = 0;

  cpfs_top u_dut (.i_clk_sys(clk), .i_nrst(nrst), .i_av_address(av_a), .i_av_read(av_rd),
    .i_av_write(av_wr), .i_av_writedata(av_wd), .o_av_readdata(av_rdata),
    .o_av_waitrequest(av_wait), .i_interface_mode_strap(strap), .i_bus_style_strap(bstyle),
    .i_tx_clk_src_sel_1(tclk1), .i_ad_pin(ad_wire), .o_ad_pin(ad_out), .o_ad_pin_oe(ad_oe),
    .i_addr_pin(addr_wire), .i_par_rdata(par_rdata), .i_par_rd_drive(rd_drv),
    .o_par_ad_shared(shared), .o_par_nonmux(nonmux), .o_par_data_in(data_in),
    .o_par_addr(par_addr), .o_bus_style_strobe(strobe), .i_spi_miso(miso),
    .i_spi_miso_drive(miso_drv), .o_spi_en(spi_en), .o_spi_mosi(mosi), .o_spi_cpol(cpol),
    .o_spi_cpha(cpha), .i_tx_mode_t1e1(t1e1), .i_tx_mode_cc(cc), .o_hw_mode(hw),
    .o_rx_mode_sel_bit3(rx3), .o_tx_mode_sel_bit0(tx0), .o_prescale_sel_0(psel),
    .o_buildout_sel(bo), .o_term_75_ohm(term), .o_zero_sub_code_en(zsub),
    .o_tx_send_ais(ais), .o_tx_force_ones(ones), .o_tx_clk_src_sel(csrc));

  cpfs_host_model u_host (.i_clk_sys(clk), .i_nrst(nrst), .i_dut_ad(ad_out), .i_dut_oe(ad_oe),
    .i_host_ad(h_ad), .i_host_oe(h_oe), .i_host_addr(h_addr), .i_mux_sel(strap == 2'h0),
    .o_ad_wire(ad_wire), .o_addr_wire(addr_wire));

  // ==========================================================
  // clock, timeout and verdict
  initial begin
    forever #25 clk = ~clk;
  end

  // ceiling well above the roughly 130 cycles the scenarios need
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails = fails + 1;
      $display("BAD t=%0t cycles %h exp %h", $time, cyc, 20000);
      finish_test();
    end
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run = tests_run + 1;
    if (got !== exp) begin
      fails = fails + 1;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // ==========================================================
  // avalon master: hold request until waitrequest is sampled low
  task automatic av_xfer(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    av_a <= a;
    av_wd <= d;
    av_rd <= ~wr;
    av_wr <= wr;
    do begin
      @(posedge clk);
      n++;
    end while (av_wait !== 1'b0 && n < 200);
    if (n >= 200) begin
      fails = fails + 1;
      $display("BAD t=%0t waitrequest %h exp %h", $time, av_wait, 1'b0);
    end
    rd = av_rdata;
    av_rd <= 1'b0;
    av_wr <= 1'b0;
  endtask

  // pins pass a synchroniser and filter before outputs follow
  task automatic settle();
    repeat (8) @(posedge clk);
  endtask

  // ==========================================================
  // scenarios
  task automatic t_regs();
    av_xfer(1'b0, 4'h0, 32'h0); chk(rd, 32'h0000_0000);
    av_xfer(1'b0, 4'hc, 32'h0); chk(rd, 32'h0000_0000);
    av_xfer(1'b1, 4'hc, 32'hffff_ffff);
    av_xfer(1'b1, 4'h4, 32'hffff_ffff);
    av_xfer(1'b0, 4'h0, 32'h0); chk(rd, 32'h0000_0000);
  endtask

  task automatic t_mux();
    strap <= 2'h0; h_oe <= 8'hff; h_ad <= 8'h5a; h_addr <= 7'h7f; bstyle <= 1'b1;
    settle();
    chk({shared, nonmux, hw, spi_en}, 4'h8);
    chk(data_in, 8'h5a);
    chk(par_addr, 7'h00);
    chk(strobe, 1'b1);
    chk({psel, bo, term}, 5'h00);
    av_xfer(1'b0, 4'h8, 32'h0); chk(rd, 32'h0000_005a);
  endtask

  task automatic t_nonmux();
    strap <= 2'h1; h_ad <= 8'ha5; h_addr <= 7'h55; bstyle <= 1'b0;
    settle();
    chk({shared, nonmux, hw, spi_en}, 4'h4);
    chk(data_in, 8'ha5);
    chk(par_addr, 7'h55);
    chk(strobe, 1'b0);
    h_oe <= 8'h00; par_rdata <= 8'h3c; rd_drv <= 1'b1;
    settle();
    chk({ad_oe, ad_out}, 16'hff3c);
    av_xfer(1'b1, 4'h0, 32'h1);
    settle();
    chk(ad_oe, 8'h00);
    av_xfer(1'b0, 4'h4, 32'h0); chk(rd[3:0], 4'h9);
    av_xfer(1'b1, 4'h0, 32'h0);
    settle();
    chk(ad_oe, 8'hff);
    rd_drv <= 1'b0; h_oe <= 8'hff;
  endtask

  task automatic t_serial();
    strap <= 2'h2; h_oe <= 8'hfe; h_ad <= 8'h02; h_addr <= 7'h20; miso <= 1'b1;
    miso_drv <= 1'b1;
    settle();
    chk({shared, nonmux, hw, spi_en}, 4'h1);
    chk({mosi, cpol, cpha}, 3'h6);
    chk({ad_oe[0], ad_out[0], ad_oe[1]}, 3'h6);
    h_ad <= 8'h00; h_addr <= 7'h10; miso <= 1'b0;
    settle();
    chk({mosi, cpol, cpha}, 3'h1);
    chk({ad_oe[0], ad_out[0]}, 2'h2);
    miso_drv <= 1'b0; h_oe <= 8'hff;
  endtask

  task automatic t_hw();
    strap <= 2'h3; h_ad <= 8'h03; h_addr <= 7'h55; tclk1 <= 1'b1; t1e1 <= 1'b1;
    bstyle <= 1'b1;
    settle();
    chk({shared, nonmux, hw, spi_en, ad_oe}, 12'h200);
    chk({rx3, tx0, psel}, 3'h5);
    chk({bo, term}, 4'hb);
    chk({zsub, ais, ones, csrc}, 5'h13);
    av_xfer(1'b0, 4'h4, 32'h0); chk(rd, 32'h0000_0037);
    h_addr <= 7'h2a; h_ad <= 8'h00; tclk1 <= 1'b0;
    settle();
    chk({rx3, tx0, psel, bo, term}, 7'h24);
    chk({zsub, ais, ones, csrc}, 5'h18);
    t1e1 <= 1'b0; cc <= 1'b1;
    settle();
    chk({zsub, ais, ones}, 3'h0);
    h_addr <= 7'h28;
    settle();
    chk({zsub, ais, ones}, 3'h1);
  endtask

  // ==========================================================
  // main sequence
  initial begin
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    t_regs();
    t_mux();
    t_nonmux();
    t_serial();
    t_hw();
    finish_test();
  end
endmodule
